//--- hw/tfl_pkg.sv
// Package: register map, field positions and timing constants of the legacy data-link channel
package tfl_pkg;
   // Register indices on APB; the byte address is the index times four
   localparam logic [7:0]  IDX_TX_BYTE      = 8'hC1;
   localparam logic [7:0]  IDX_RX_BYTE      = 8'hC2;
   localparam logic [7:0]  IDX_MATCH_A      = 8'hC3;
   localparam logic [7:0]  IDX_MATCH_B      = 8'hC4;
   localparam logic [7:0]  IDX_STATUS       = 8'hC5;
   localparam logic [7:0]  IDX_MASK         = 8'hC6;
   localparam logic [7:0]  IDX_RX_CTRL_B    = 8'hC7;
   localparam logic [7:0]  IDX_TX_CTRL_A    = 8'hC8;
   localparam logic [7:0]  IDX_TX_CTRL_B    = 8'hC9;
   localparam int          ADDR_W           = 12;
   // Field positions
   localparam int          ST_MATCH         = 1;
   localparam int          ST_TX_EMPTY      = 2;
   localparam int          ST_RX_FULL       = 3;
   localparam int          RXC_DESTUFF      = 3;
   localparam int          TXA_FS_EXT       = 2;
   localparam int          TXB_STUFF        = 5;
   localparam int          TXB_MF_LOAD      = 6;
   // Reset values
   localparam logic [7:0]  RST_BYTE         = 8'h00;
   localparam logic [3:0]  RST_FLAGS        = 4'h0;
   // Byte and run lengths
   localparam logic [2:0]  LAST_BIT         = 3'h7;
   localparam logic [2:0]  RUN_LIMIT        = 3'h5;
   localparam logic [2:0]  RUN_SAT          = 3'h6;
   // Timing of a data-link bit
   localparam int          CLK_HZ           = 50_000_000;
   localparam int          BIT_PERIOD_US    = 250;
   localparam int          BITS_PER_BYTE    = 8;
   localparam int          BIT_CYCLES       = CLK_HZ / 1_000_000 * BIT_PERIOD_US;
   localparam int          BYTE_CYCLES      = BIT_CYCLES * BITS_PER_BYTE;
endpackage

//--- hw/tfl_run_counter.sv
// Consecutive-ones run counter shared by the stuffer and the destuffer
`timescale 1ns/1ns
module tfl_run_counter
   import tfl_pkg::*;
(
   input  wire logic       MCLK,
   input  wire logic       RESET_N,
   input  wire logic       BIT_STB,
   input  wire logic       BIT_VAL,
   output logic [2:0]      RUN
);
   // Counts ones across byte boundaries, cleared by any zero; saturates so six-plus stays visible
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         RUN <= 3'h0;
      end else if (BIT_STB) begin
         if (!BIT_VAL) RUN <= 3'h0;
         else if (RUN != RUN_SAT) RUN <= RUN + 3'h1;
      end
   end
endmodule // tfl_run_counter

//--- hw/tfl_channel.sv
// Legacy T1 data-link channel: receive extractor, transmit serialiser, APB register file
`timescale 1ns/1ns
// Functional notes
// - Shift recovered link bits into 8-bit receive register
// - Receive byte completes every eight 250us bits
// - Receive full sets status bit 3, maskable
// - Match either programmed byte sets status bit 1
// - Destuff enabled: drop zero after five ones
// - Six or more ones: zero kept
// - Transmit byte into link bits or Fs bits
// - New transmit byte sent LSB first
// - Eight bits sent sets status bit 2, maskable
// - No new write: resend previous byte
// - Stuff enabled: insert zero after five ones
// - Transmit control A bit2 zero in D4 mode: Fs from register
// - Control B bit6: load only at multiframe
// - SLC-96 fields travel through same registers
module tfl_channel
   import tfl_pkg::*;
(
   input  wire logic                 MCLK,
   input  wire logic                 RESET_N,
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire logic [ADDR_W-1:0]    PADDR,
   input  wire logic [31:0]          PWDATA,
   output logic [31:0]               PRDATA,
   output logic                      PREADY,
   output logic                      PSLVERR,
   input  wire logic                 RX_LINK_BIT,
   input  wire logic                 RX_LINK_STB,
   input  wire logic                 TX_LINK_STB,
   input  wire logic                 TX_MF_BOUNDARY,
   input  wire logic                 D4_MODE,
   output logic                      TX_LINK_BIT,
   output logic                      TX_FS_FROM_REG,
   output logic                      INT_N
);
   import tfl_pkg::*;

   // Decode a byte address into a register index match
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00})) ? 1'b1 : 1'b0;
   endfunction

   typedef enum logic [1:0] {
      TFL_IDLE  = 2'b00,
      TFL_SETUP = 2'b01,
      TFL_DONE  = 2'b11
   } tfl_apb_type;

   tfl_apb_type  apb_r;
   tfl_apb_type  apb_nxt;

   logic [7:0]   tx_byte_r;
   logic [7:0]   rx_byte_r;
   logic [7:0]   rx_shift_r;
   logic [2:0]   rx_cnt_r;
   logic [7:0]   match_a_r;
   logic [7:0]   match_b_r;
   logic [3:0]   status_r;
   logic [3:0]   mask_r;
   logic [7:0]   rx_ctrl_r;
   logic [7:0]   tx_ctrl_a_r;
   logic [7:0]   tx_ctrl_b_r;
   logic [7:0]   tx_shift_r;
   logic [2:0]   tx_cnt_r;
   logic         tx_bit_r;
   logic         rx_s1_r;
   logic         rx_s2_r;
   logic         rxs_s1_r;
   logic         rxs_s2_r;
   logic         rxs_s3_r;
   logic         txs_s1_r;
   logic         txs_s2_r;
   logic         txs_s3_r;
   logic         mf_s1_r;
   logic         mf_s2_r;
   logic         d4_s1_r;
   logic         d4_s2_r;
   logic [31:0]  prdata_r;
   logic         pready_r;
   logic         pslverr_r;
   logic         int_n_r;
   logic [2:0]   rx_run;
   logic [2:0]   tx_run;

   // Pin inputs pass two flops; strobes get a third stage for edge detection
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         {rx_s1_r, rx_s2_r, rxs_s1_r, rxs_s2_r, rxs_s3_r} <= 5'h00;
         {txs_s1_r, txs_s2_r, txs_s3_r, mf_s1_r, mf_s2_r, d4_s1_r, d4_s2_r} <= 7'h00;
      end else begin
         {rx_s2_r, rx_s1_r} <= {rx_s1_r, RX_LINK_BIT};
         {rxs_s3_r, rxs_s2_r, rxs_s1_r} <= {rxs_s2_r, rxs_s1_r, RX_LINK_STB};
         {txs_s3_r, txs_s2_r, txs_s1_r} <= {txs_s2_r, txs_s1_r, TX_LINK_STB};
         {mf_s2_r, mf_s1_r} <= {mf_s1_r, TX_MF_BOUNDARY};
         {d4_s2_r, d4_s1_r} <= {d4_s1_r, D4_MODE};
      end
   end

   // Bus decode
   wire          acc      = PSEL && PENABLE && (apb_r == TFL_SETUP);
   wire          wr       = PSEL && PENABLE && PWRITE && pready_r; // Lands only where ready is seen
   wire          rd       = acc && !PWRITE;
   wire          h_tx     = hit(PADDR, IDX_TX_BYTE);
   wire          h_rx     = hit(PADDR, IDX_RX_BYTE);
   wire          h_ma     = hit(PADDR, IDX_MATCH_A);
   wire          h_mb     = hit(PADDR, IDX_MATCH_B);
   wire          h_st     = hit(PADDR, IDX_STATUS);
   wire          h_mk     = hit(PADDR, IDX_MASK);
   wire          h_rc     = hit(PADDR, IDX_RX_CTRL_B);
   wire          h_ta     = hit(PADDR, IDX_TX_CTRL_A);
   wire          h_tb     = hit(PADDR, IDX_TX_CTRL_B);
   wire          mapped   = h_tx | h_rx | h_ma | h_mb | h_st | h_mk | h_rc | h_ta | h_tb;
   wire [31:0]   rd_mux   = h_tx ? {24'h000000, tx_byte_r} :
                            h_rx ? {24'h000000, rx_byte_r} :
                            h_ma ? {24'h000000, match_a_r} :
                            h_mb ? {24'h000000, match_b_r} :
                            h_st ? {28'h0000000, status_r} :
                            h_mk ? {28'h0000000, mask_r} :
                            h_rc ? {24'h000000, rx_ctrl_r} :
                            h_ta ? {24'h000000, tx_ctrl_a_r} :
                            h_tb ? {24'h000000, tx_ctrl_b_r} : 32'h00000000;

   // Receive bit path: a zero after exactly five ones is a stuffed bit and is dropped
   wire          rx_stb   = rxs_s2_r && !rxs_s3_r;
   wire          rx_drop  = rx_ctrl_r[RXC_DESTUFF] && !rx_s2_r && (rx_run == RUN_LIMIT);
   wire          rx_take  = rx_stb && !rx_drop;
   wire [7:0]    rx_full  = {rx_s2_r, rx_shift_r[7:1]};
   wire          rx_done  = rx_take && (rx_cnt_r == LAST_BIT);
   wire          rx_hit   = rx_done && ((rx_full == match_a_r) || (rx_full == match_b_r));

   // Transmit bit path: after five ones a zero goes out and the data bit waits
   wire          tx_stb   = txs_s2_r && !txs_s3_r;
   wire          tx_stuff = tx_ctrl_b_r[TXB_STUFF] && (tx_run >= RUN_LIMIT);
   wire          tx_out   = tx_stuff ? 1'b0 : tx_shift_r[0];
   wire          tx_adv   = tx_stb && !tx_stuff;
   wire          tx_last  = tx_adv && (tx_cnt_r == LAST_BIT);
   wire          mf_ok    = !tx_ctrl_b_r[TXB_MF_LOAD] || mf_s2_r;
   wire          tx_load  = tx_last && mf_ok;
   wire [7:0]    tx_rot   = {tx_shift_r[0], tx_shift_r[7:1]}; // Full turn replays the old byte

   tfl_run_counter u_rx_run (
      .MCLK    (MCLK),
      .RESET_N (RESET_N),
      .BIT_STB (rx_stb),
      .BIT_VAL (rx_s2_r),
      .RUN     (rx_run)
   );

   tfl_run_counter u_tx_run (
      .MCLK    (MCLK),
      .RESET_N (RESET_N),
      .BIT_STB (tx_stb),
      .BIT_VAL (tx_out),
      .RUN     (tx_run)
   );

   // APB: one setup cycle, then two access cycles with pready high in the second
   always_comb begin
      case (apb_r)
         TFL_IDLE:  apb_nxt = PSEL ? TFL_SETUP : TFL_IDLE;
         TFL_SETUP: apb_nxt = acc ? TFL_DONE : TFL_SETUP;
         TFL_DONE:  apb_nxt = TFL_IDLE;
         default:   apb_nxt = TFL_IDLE;
      endcase
   end

   // Bus answer registers; pready is raised one cycle into the access phase
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         apb_r     <= TFL_IDLE;
         prdata_r  <= 32'h00000000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         apb_r     <= apb_nxt;
         pready_r  <= acc;
         pslverr_r <= acc && !mapped;
         prdata_r  <= rd ? rd_mux : 32'h00000000;
      end
   end

   // Control and match registers written by software
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         {match_a_r, match_b_r, rx_ctrl_r} <= {RST_BYTE, RST_BYTE, RST_BYTE};
         {tx_ctrl_a_r, tx_ctrl_b_r} <= {RST_BYTE, RST_BYTE};
         mask_r <= RST_FLAGS;
      end else if (wr) begin
         if (h_ma) match_a_r <= PWDATA[7:0];
         if (h_mb) match_b_r <= PWDATA[7:0];
         if (h_rc) rx_ctrl_r <= PWDATA[7:0];
         if (h_ta) tx_ctrl_a_r <= PWDATA[7:0];
         if (h_tb) tx_ctrl_b_r <= PWDATA[7:0];
         if (h_mk) mask_r <= PWDATA[3:0];
      end
   end

   // Receive shifter; a full byte overwrites the holding register even if unread
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         rx_shift_r <= RST_BYTE;
         rx_cnt_r   <= 3'h0;
         rx_byte_r  <= RST_BYTE;
      end else if (rx_take) begin
         rx_shift_r <= rx_full;
         rx_cnt_r   <= rx_cnt_r + 3'h1;
         if (rx_done) rx_byte_r <= rx_full;
      end
   end

   // Transmit holding and shift registers; the old byte repeats if nothing new arrived
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         tx_byte_r  <= RST_BYTE;
         tx_shift_r <= RST_BYTE;
         tx_cnt_r   <= 3'h0;
      end else begin
         if (wr && h_tx) tx_byte_r <= PWDATA[7:0];
         if (tx_load) tx_shift_r <= tx_byte_r;
         else if (tx_adv) tx_shift_r <= tx_rot;
         if (tx_adv) tx_cnt_r <= tx_cnt_r + 3'h1;
      end
   end

   // Sticky flags: hardware set beats a software write-one-to-clear in the same cycle
   wire [3:0]    clr_w    = (wr && h_st) ? PWDATA[3:0] : 4'h0;
   wire [3:0]    set_w    = {rx_done, tx_last, rx_hit, 1'b0};
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         status_r <= RST_FLAGS;
      end else begin
         status_r <= (status_r & ~clr_w) | set_w;
      end
   end

   // Output pins from flops; interrupt follows any enabled flag
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         tx_bit_r <= 1'b0;
         int_n_r  <= 1'b1;
      end else begin
         if (tx_stb) tx_bit_r <= tx_out;
         int_n_r <= ~|(status_r & mask_r);
      end
   end

   // Fs source select is a level; D4 and ESF both use the same bit slot strobe
   logic fs_reg_r;
   always_ff @(posedge MCLK) begin
      if (!RESET_N) fs_reg_r <= 1'b0;
      else fs_reg_r <= d4_s2_r && !tx_ctrl_a_r[TXA_FS_EXT];
   end

   assign PRDATA         = prdata_r;
   assign PREADY         = pready_r;
   assign PSLVERR        = pslverr_r;
   assign TX_LINK_BIT    = tx_bit_r;
   assign TX_FS_FROM_REG = fs_reg_r;
   assign INT_N          = int_n_r;

   a_rx_full_flag: assert property (@(posedge MCLK) disable iff (!RESET_N)
      rx_done |=> status_r[ST_RX_FULL]) else $error("receive full not set");
   a_match_flag: assert property (@(posedge MCLK) disable iff (!RESET_N)
      rx_hit |=> status_r[ST_MATCH]) else $error("match not set");
   a_tx_empty_flag: assert property (@(posedge MCLK) disable iff (!RESET_N)
      tx_last |=> status_r[ST_TX_EMPTY]) else $error("transmit empty not set");
   a_irq_level: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (|(status_r & mask_r)) |=> !INT_N) else $error("interrupt not asserted");
   a_destuff_drop: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (rx_stb && rx_ctrl_r[RXC_DESTUFF] && !rx_s2_r && rx_run == RUN_LIMIT) |=> $stable(rx_cnt_r))
      else $error("stuffed zero kept");
   a_six_ones_keep: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (rx_stb && !rx_s2_r && rx_run == RUN_SAT) |=> rx_cnt_r == $past(rx_cnt_r) + 3'h1)
      else $error("zero after six ones dropped");
   a_stuff_zero: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (tx_stb && tx_ctrl_b_r[TXB_STUFF] && tx_run == RUN_LIMIT) |=> !TX_LINK_BIT)
      else $error("stuff zero missing");
   a_mf_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (tx_last && tx_ctrl_b_r[TXB_MF_LOAD] && !mf_s2_r) |=> tx_shift_r == $past(tx_rot))
      else $error("load off multiframe");
   a_run_clear: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (tx_stb && !tx_out) |=> tx_run == 3'h0) else $error("run not cleared");
   // Hand-over checks: receive holding and transmit shift registers take exactly the assembled or held byte
   a_rx_byte_load: assert property (@(posedge MCLK) disable iff (!RESET_N)
      rx_done |=> rx_byte_r == $past(rx_full)) else $error("receive byte not loaded");
   a_tx_byte_load: assert property (@(posedge MCLK) disable iff (!RESET_N)
      tx_load |=> tx_shift_r == $past(tx_byte_r)) else $error("transmit byte not loaded");
   a_irq_release: assert property (@(posedge MCLK) disable iff (!RESET_N)
      !(|(status_r & mask_r)) |=> INT_N) else $error("interrupt without enabled flag");
endmodule // tfl_channel

//--- bench/tfl_link_model.sv
// Far-end link model: bit strobes into the receiver, slot strobes and capture on transmit
`timescale 1ns/1ns
module tfl_link_model (
   input  wire logic MCLK,
   input  wire logic RESET_N,
   input  wire logic TX_RUN,
   input  wire logic TX_LINK_BIT,
   output logic      RX_LINK_BIT,
   output logic      RX_LINK_STB,
   output logic      TX_LINK_STB
);
   logic [3:0] slot_cnt;
   logic       tx_q[$];
   initial begin
      RX_LINK_BIT = 1'b0;
      RX_LINK_STB = 1'b0;
   end
   // One bit: data settles before the strobe, then the line shows the inverse so stale data never matches
   task automatic send_bit(input logic b);
      @(posedge MCLK) RX_LINK_BIT <= b;
      repeat (2) @(posedge MCLK);
      RX_LINK_STB <= 1'b1;
      repeat (4) @(posedge MCLK);
      RX_LINK_STB <= 1'b0;
      RX_LINK_BIT <= ~b;
      repeat (4) @(posedge MCLK);
   endtask
   // Slot strobe every 16 cycles; the bit is taken well after it settles
   assign TX_LINK_STB = RESET_N && TX_RUN && slot_cnt < 4'h4;
   always_ff @(posedge MCLK) begin
      slot_cnt <= (RESET_N && TX_RUN) ? slot_cnt + 4'h1 : 4'h0;
      if (RESET_N && TX_RUN && slot_cnt == 4'hA) tx_q.push_back(TX_LINK_BIT);
   end
endmodule // tfl_link_model

//--- bench/tfl_channel_tb_top.sv
// Self-checking bench of the legacy data-link channel
`timescale 1ns/1ns
module tfl_channel_tb_top;
   import tfl_pkg::*;
   logic              mclk = 1'b0;
   logic              reset_n = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              rx_bit;
   logic              rx_stb;
   logic              tx_stb;
   logic              mf_bnd = 1'b0;
   logic              d4_mode = 1'b0;
   logic              tx_bit;
   logic              fs_reg;
   logic              int_n;
   logic              tx_run = 1'b0;
   int                err_total = 0;
   int                comparisons = 0;
   int                ref_run = 0;
   int                ref_cnt = 0;
   int                n0 = 0;
   logic [31:0]       seed = 32'd31643;
   logic [31:0]       q;
   logic [31:0]       st;
   logic              slv;
   logic [7:0]        ma;
   logic [7:0]        mb;
   logic [7:0]        mk;
   logic [7:0]        v;
   logic [7:0]        ref_sh = 8'h00;
   logic              destuff = 1'b0;
   logic              exp_q[$];
   localparam logic [24:0] RAW = 25'h17FDF00;

   tfl_channel i_tfl_channel (.MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_LINK_BIT(rx_bit),
      .RX_LINK_STB(rx_stb), .TX_LINK_STB(tx_stb), .TX_MF_BOUNDARY(mf_bnd), .D4_MODE(d4_mode),
      .TX_LINK_BIT(tx_bit), .TX_FS_FROM_REG(fs_reg), .INT_N(int_n));
   tfl_link_model i_tfl_link_model (.MCLK(mclk), .RESET_N(reset_n), .TX_RUN(tx_run), .TX_LINK_BIT(tx_bit),
      .RX_LINK_BIT(rx_bit), .RX_LINK_STB(rx_stb), .TX_LINK_STB(tx_stb));

   initial forever #10 mclk = ~mclk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset;
      @(posedge mclk) reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
   endtask
   // Request held until ready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge mclk) begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= {2'b00, idx, 2'b00};
         pwdata <= d;
      end
      @(posedge mclk) penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reference receiver: destuff, shift LSB first, check flags and byte per completed byte
   task automatic rx_in(input logic b);
      i_tfl_link_model.send_bit(b);
      if (destuff && !b && ref_run == 5) ref_run = 0;
      else begin
         ref_run = b ? ref_run + 1 : 0;
         ref_sh = {b, ref_sh[7:1]};
         ref_cnt++;
         if (ref_cnt == 8) begin
            ref_cnt = 0;
            apb(1'b0, IDX_STATUS, 32'h0);
            st = q;
            chk(32'(st[ST_RX_FULL]), 32'h1);
            chk(32'(st[ST_MATCH]), 32'(ref_sh == ma || ref_sh == mb));
            chk(32'(int_n), 32'(~|(st[3:0] & mk[3:0])));
            apb(1'b0, IDX_RX_BYTE, 32'h0);
            chk(q, 32'(ref_sh));
            apb(1'b1, IDX_STATUS, 32'hE);
         end
      end
   endtask
   // Reference transmit stream, stuffing a zero after five ones
   task automatic push_byte(input logic [7:0] b, input logic stuff);
      for (int i = 0; i < 8; i++) begin
         exp_q.push_back(b[i]);
         ref_run = b[i] ? ref_run + 1 : 0;
         if (stuff && ref_run == 5) begin
            exp_q.push_back(1'b0);
            ref_run = 0;
         end
      end
   endtask
   task automatic wait_empty;
      do apb(1'b0, IDX_STATUS, 32'h0); while (q[ST_TX_EMPTY] !== 1'b1);
      apb(1'b1, IDX_STATUS, 32'h4);
   endtask
   task automatic cmp_tx(input int n);
      while (i_tfl_link_model.tx_q.size() < n) @(posedge mclk);
      for (int i = 0; i < n; i++) chk(32'(i_tfl_link_model.tx_q[i]), 32'(exp_q[i]));
   endtask

   // Watchdog: whole sequence needs well under this
   initial begin
      repeat (30000) @(posedge mclk);
      err_total++;
      report_and_stop();
   end

   initial begin
      do_reset();
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, IDX_TX_BYTE + 8'(i), 32'h0);
         chk(q, 32'(RST_BYTE));
      end
      apb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0);
      chk(32'(slv), 32'h1);
      // Receive: random bytes with masks, both match bytes, then destuffing
      ma = 8'(rnd());
      mb = 8'(rnd());
      apb(1'b1, IDX_MATCH_A, 32'(ma));
      apb(1'b1, IDX_MATCH_B, 32'(mb));
      for (int k = 0; k < 8; k++) begin
         v = k == 2 ? ma : k == 5 ? mb : 8'(rnd());
         mk = 8'(rnd()) & 8'h0E;
         apb(1'b1, IDX_MASK, 32'(mk));
         for (int j = 0; j < 8; j++) rx_in(v[j]);
      end
      destuff = 1'b1;
      apb(1'b1, IDX_RX_CTRL_B, 32'h8);
      for (int j = 0; j < 25; j++) rx_in(RAW[j]);
      // Transmit: reset byte, new byte, repeat, next byte
      do_reset();
      ref_run = 0;
      @(posedge mclk) tx_run <= 1'b1;
      v = 8'(rnd());
      apb(1'b1, IDX_TX_BYTE, 32'(v));
      push_byte(8'h00, 1'b0);
      push_byte(v, 1'b0);
      push_byte(v, 1'b0);
      wait_empty();
      wait_empty();
      v = 8'(rnd());
      apb(1'b1, IDX_TX_BYTE, 32'(v));
      push_byte(v, 1'b0);
      wait_empty();
      wait_empty();
      cmp_tx(32);
      @(posedge mclk) d4_mode <= 1'b1;
      apb(1'b1, IDX_TX_BYTE, 32'h1C);
      apb(1'b1, IDX_TX_CTRL_A, 32'h0);
      repeat (3) @(posedge mclk);
      chk(32'(fs_reg), 32'h1);
      apb(1'b1, IDX_TX_CTRL_A, 32'h4);
      repeat (3) @(posedge mclk);
      chk(32'(fs_reg), 32'h0);
      // Transmit with stuffing, reset taken after the link strobes are stopped
      @(posedge mclk) tx_run <= 1'b0;
      do_reset();
      i_tfl_link_model.tx_q.delete();
      exp_q.delete();
      ref_run = 0;
      apb(1'b1, IDX_TX_CTRL_B, 32'h20);
      apb(1'b1, IDX_TX_BYTE, 32'hFF);
      @(posedge mclk) tx_run <= 1'b1;
      push_byte(8'h00, 1'b1);
      push_byte(8'hFF, 1'b1);
      push_byte(8'hFF, 1'b1);
      wait_empty();
      wait_empty();
      wait_empty();
      cmp_tx(24);
      // Multiframe load: the written byte waits for a boundary while the reset byte repeats
      @(posedge mclk) tx_run <= 1'b0;
      do_reset();
      i_tfl_link_model.tx_q.delete();
      apb(1'b1, IDX_TX_CTRL_B, 32'h40);
      apb(1'b1, IDX_TX_BYTE, 32'hFF);
      @(posedge mclk) tx_run <= 1'b1;
      while (i_tfl_link_model.tx_q.size() < 24) @(posedge mclk);
      for (int i = 0; i < 24; i++) chk(32'(i_tfl_link_model.tx_q[i]), 32'h0);
      @(posedge mclk) mf_bnd <= 1'b1;
      n0 = i_tfl_link_model.tx_q.size();
      while (i_tfl_link_model.tx_q.size() < n0 + 18) @(posedge mclk);
      for (int i = 10; i < 18; i++) chk(32'(i_tfl_link_model.tx_q[n0 + i]), 32'h1);
      report_and_stop();
   end
endmodule // tfl_channel_tb_top
